//--- core/lbt_pkg.sv
// Constants and types shared by the logic and bit-test decode block.
// Function
// - AND opcodes 52-59 store dst AND src, Z/S from result, V cleared, C kept.
// - Guard opcode 2F blocks interrupt and DMA service for next 3 instructions.
// - Each flag is from result, kept, undefined, forced 0 or forced 1.
// - Opcodes F6/F7 add X to PC only when the tested bit is 0.
// - Break opcode 00 signals debug unit; disabled breakpoints make it a no-op.
package lbt_pkg;

  // **********************************************************************
  // Opcodes
  // **********************************************************************
  localparam logic [7:0] OP_AND_FIRST   = 8'h52;
  localparam logic [7:0] OP_AND_LAST    = 8'h57;
  localparam logic [7:0] OP_EXTENDED_AND_OP_FIRST  = 8'h58;
  localparam logic [7:0] OP_EXTENDED_AND_OP_LAST   = 8'h59;
  localparam logic [7:0] OP_ATOMIC      = 8'h2F;
  localparam logic [7:0] OP_BTJ_REG     = 8'hF6;
  localparam logic [7:0] OP_BTJ_IND     = 8'hF7;
  localparam logic [7:0] OP_DBG_HALT    = 8'h00;

  // **********************************************************************
  // Flag positions and timing
  // **********************************************************************
  localparam int FLAG_C = 5;
  localparam int FLAG_Z = 4;
  localparam int FLAG_S = 3;
  localparam int FLAG_V = 2;
  localparam int FLAG_D = 1;
  localparam int FLAG_H = 0;
  localparam int NUM_FLAGS = 6;
  localparam logic [5:0] FLAGS_RST = 6'h00;
  localparam int GUARD_LEN = 3;

  typedef enum logic [2:0] {
    FT_RESULT = 3'h0,
    FT_KEEP   = 3'h1,
    FT_UNDEF  = 3'h2,
    FT_ZERO   = 3'h3,
    FT_ONE    = 3'h4
  } lbt_ftreat_t;

endpackage

//--- core/lbt_flag_if.sv
// Carrier between the decoder and its flag update unit.
`timescale 1ns/1ps
interface lbt_flag_if;
  logic                          [7:0] result;
  logic                          [5:0] old_flags;
  lbt_pkg::lbt_ftreat_t          [5:0] treat;
  logic                          [5:0] new_flags;

  modport ctrl (output result, output old_flags, output treat,
                input new_flags);
  modport unit (input result, input old_flags, input treat,
                output new_flags);
endinterface

//--- core/lbt_flag_unit.sv
// Flag update unit: applies one of five treatments to every flag.
`timescale 1ns/1ps
module lbt_flag_unit (
  lbt_flag_if.unit fl
);

  // **********************************************************************
  // Treatment selection
  // **********************************************************************
  // Undefined flags keep their old value; that is one legal outcome and
  // keeps the unit free of pseudo-random state.
  function automatic logic apply_treat(lbt_pkg::lbt_ftreat_t t,
                                       logic old_v, logic calc_v);
    logic v;
    v = old_v;
    unique case (t)
      lbt_pkg::FT_RESULT: v = calc_v;
      lbt_pkg::FT_KEEP:   v = old_v;
      lbt_pkg::FT_UNDEF:  v = old_v;
      lbt_pkg::FT_ZERO:   v = 1'b0;
      lbt_pkg::FT_ONE:    v = 1'b1;
      default:            v = old_v;
    endcase
    return v;
  endfunction

  wire [5:0] calc_flags;

  assign calc_flags[lbt_pkg::FLAG_C] = fl.old_flags[lbt_pkg::FLAG_C];
  assign calc_flags[lbt_pkg::FLAG_Z] = ~|fl.result;
  assign calc_flags[lbt_pkg::FLAG_S] = fl.result[7];
  assign calc_flags[lbt_pkg::FLAG_V] = fl.old_flags[lbt_pkg::FLAG_V];
  assign calc_flags[lbt_pkg::FLAG_D] = fl.old_flags[lbt_pkg::FLAG_D];
  assign calc_flags[lbt_pkg::FLAG_H] = fl.old_flags[lbt_pkg::FLAG_H];

  for (genvar i = 0; i < lbt_pkg::NUM_FLAGS; i++) begin : g_flag
    assign fl.new_flags[i] = apply_treat(fl.treat[i], fl.old_flags[i],
                                         calc_flags[i]);
  end

endmodule

//--- core/lbt_decode.sv
// Decoder and executor for AND, atomic guard, bit-test jump and break.
`timescale 1ns/1ps
module lbt_decode #(
  parameter int GUARD_COUNT = lbt_pkg::GUARD_LEN
) (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        instr_valid_i,
  input  wire logic [7:0]  opcode_i,
  input  wire logic [7:0]  dst_val_i,
  input  wire logic [7:0]  src_val_i,
  input  wire logic [2:0]  bit_sel_i,
  input  wire logic [7:0]  disp_i,
  input  wire logic [15:0] pc_next_i,
  input  wire logic [5:0]  flags_i,
  input  wire logic        brk_enable_i,
  input  wire logic        irq_req_i,
  input  wire logic        dma_req_i,
  output logic      [7:0]  result_o,
  output logic             result_we_o,
  output logic      [5:0]  flags_o,
  output logic             flags_we_o,
  output logic             pc_load_o,
  output logic      [15:0] pc_target_o,
  output logic             dbg_break_o,
  output logic             nop_o,
  output logic             irq_grant_o,
  output logic             dma_grant_o,
  output logic             guard_active_o
);

  if (GUARD_COUNT < 1 || GUARD_COUNT > 15) begin : g_bad_guard
    $error("GUARD_COUNT must lie between 1 and 15");
  end

  localparam logic [3:0] GUARD_LOAD = 4'(GUARD_COUNT);

  // **********************************************************************
  // Decode
  // **********************************************************************
  function automatic logic in_range(logic [7:0] op, logic [7:0] lo,
                                    logic [7:0] hi);
    return (op >= lo) && (op <= hi);
  endfunction

  wire is_and  = instr_valid_i &&
                 (in_range(opcode_i, lbt_pkg::OP_AND_FIRST,
                           lbt_pkg::OP_AND_LAST) ||
                  in_range(opcode_i, lbt_pkg::OP_EXTENDED_AND_OP_FIRST,
                           lbt_pkg::OP_EXTENDED_AND_OP_LAST));
  wire is_atm  = instr_valid_i && (opcode_i == lbt_pkg::OP_ATOMIC);
  wire is_btj  = instr_valid_i && ((opcode_i == lbt_pkg::OP_BTJ_REG) ||
                                   (opcode_i == lbt_pkg::OP_BTJ_IND));
  wire is_brk  = instr_valid_i && (opcode_i == lbt_pkg::OP_DBG_HALT);

  // **********************************************************************
  // Datapath
  // **********************************************************************
  wire [7:0]  and_result = dst_val_i & src_val_i;
  wire        tested_bit = src_val_i[bit_sel_i];
  wire        take_jump  = is_btj && !tested_bit;
  // The displacement is signed; the PC given already points past the jump.
  wire [15:0] jump_target = pc_next_i + {{8{disp_i[7]}}, disp_i};

  lbt_flag_if fl ();

  assign fl.result    = and_result;
  assign fl.old_flags = flags_i;

  // Only AND changes flags; every other opcode here keeps all of them.
  always_comb begin
    for (int i = 0; i < lbt_pkg::NUM_FLAGS; i++) begin
      fl.treat[i] = lbt_pkg::FT_KEEP;
    end
    if (is_and) begin
      fl.treat[lbt_pkg::FLAG_Z] = lbt_pkg::FT_RESULT;
      fl.treat[lbt_pkg::FLAG_S] = lbt_pkg::FT_RESULT;
      fl.treat[lbt_pkg::FLAG_V] = lbt_pkg::FT_ZERO;
    end
  end

  lbt_flag_unit u_flag (
    .fl (fl.unit)
  );

  // **********************************************************************
  // Atomic guard
  // **********************************************************************
  logic [3:0] guard_cnt_r;
  logic [3:0] guard_cnt_nxt;

  // A guard inside a guard restarts the window rather than extending it.
  assign guard_cnt_nxt = is_atm ? GUARD_LOAD :
                         (instr_valid_i && guard_cnt_r != 4'h0) ?
                         guard_cnt_r - 4'h1 : guard_cnt_r;
  // The guard cycle itself blocks as well, so a request raised alongside
  // the guard opcode never slips through before the counter loads.
  wire guard_block = is_atm || (guard_cnt_r != 4'h0);

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      guard_cnt_r <= 4'h0;
    end else begin
      guard_cnt_r <= guard_cnt_nxt;
    end
  end

  // **********************************************************************
  // Output registers
  // **********************************************************************
  // Data outputs follow the inputs every cycle; only the strobes qualify
  // them, which saves an enable on every data flop.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      result_o       <= 8'h00;
      result_we_o    <= 1'b0;
      flags_o        <= lbt_pkg::FLAGS_RST;
      flags_we_o     <= 1'b0;
      pc_load_o      <= 1'b0;
      pc_target_o    <= 16'h0000;
      dbg_break_o    <= 1'b0;
      nop_o          <= 1'b0;
      irq_grant_o    <= 1'b0;
      dma_grant_o    <= 1'b0;
      guard_active_o <= 1'b0;
    end else begin
      result_o       <= and_result;
      result_we_o    <= is_and;
      flags_o        <= fl.new_flags;
      flags_we_o     <= is_and;
      pc_load_o      <= take_jump;
      pc_target_o    <= jump_target;
      dbg_break_o    <= is_brk && brk_enable_i;
      nop_o          <= is_brk && !brk_enable_i;
      irq_grant_o    <= irq_req_i && !guard_block;
      dma_grant_o    <= dma_req_i && !guard_block;
      guard_active_o <= guard_cnt_nxt != 4'h0;
    end
  end

  // **********************************************************************
  // Assertions
  // **********************************************************************
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Guard windows are counted in executed instructions, not cycles, so the
  // properties below that check the window closing tie their repetitions to instr_valid_i.

  AST_AND_RESULT: assert property (
    is_and |=> result_we_o && result_o == ($past(dst_val_i) &
                                           $past(src_val_i)))
    else $error("AND result differs from dst AND src");

  AST_AND_FLAGS: assert property (
    is_and |=> flags_we_o && !flags_o[lbt_pkg::FLAG_V] &&
               flags_o[lbt_pkg::FLAG_C] == $past(flags_i[lbt_pkg::FLAG_C]))
    else $error("AND did not clear V or changed C");

  AST_FLAG_RESULT: assert property (
    flags_we_o |-> flags_o[lbt_pkg::FLAG_Z] == (result_o == 8'h00) &&
                   flags_o[lbt_pkg::FLAG_S] == result_o[7])
    else $error("Z or S does not follow the result");

  AST_GUARD_BLOCK: assert property (
    is_atm ##1 (!instr_valid_i || !is_atm) [*3] |->
      !irq_grant_o && !dma_grant_o)
    else $error("Request serviced inside the guard window");

  AST_GUARD_FLAGS: assert property (
    (is_atm || is_btj || is_brk) |=> !flags_we_o)
    else $error("Guard, jump or break changed flags");

  AST_GUARD_END: assert property (
    is_atm ##1 (instr_valid_i && !is_atm) [*3] ##1
      (irq_req_i && !is_atm) |=> irq_grant_o)
    else $error("Guard held past three instructions");

  AST_JUMP_TAKEN: assert property (
    is_btj |=> pc_load_o == !$past(tested_bit))
    else $error("Jump decision does not match tested bit");

  AST_JUMP_TARGET: assert property (
    take_jump |=> pc_target_o == $past(pc_next_i) +
                  {{8{$past(disp_i[7])}}, $past(disp_i)})
    else $error("Jump target is not PC plus signed displacement");

  AST_BREAK: assert property (
    is_brk |=> (dbg_break_o != nop_o) &&
               dbg_break_o == $past(brk_enable_i))
    else $error("Break handling does not follow the enable");

  AST_GUARD_FIRST: assert property (
    is_atm |=> !irq_grant_o && !dma_grant_o)
    else $error("Request serviced in the guard cycle itself");

  AST_GUARD_THIRD: assert property (
    is_atm ##1 (!is_atm) [*3] |=>
      !irq_grant_o && !dma_grant_o)
    else $error("Request serviced during the third guarded instruction");

  AST_DMA_END: assert property (
    is_atm ##1 (instr_valid_i && !is_atm) [*3] ##1
      (dma_req_i && !is_atm) |=> dma_grant_o)
    else $error("DMA held off past three instructions");

  AST_GUARD_ACTIVE: assert property (
    is_atm |=> guard_active_o)
    else $error("Guard opcode did not open the window");

  AST_GUARD_CLOSE: assert property (
    is_atm ##1 (instr_valid_i && !is_atm) [*3] |=>
      !guard_active_o)
    else $error("Guard window open after three instructions");

  AST_REFUSED: assert property (
    !(is_and || is_atm || is_btj || is_brk) |=>
      !result_we_o && !flags_we_o && !pc_load_o && !dbg_break_o && !nop_o)
    else $error("Uncovered opcode or idle cycle raised a strobe");

  COV_AND:   cover property (is_and ##1 flags_o[lbt_pkg::FLAG_Z]);
  COV_GUARD: cover property (is_atm ##1 irq_req_i ##3 irq_req_i);
  COV_JUMP:  cover property (take_jump && disp_i[7]);
  COV_NOP:   cover property (is_brk && !brk_enable_i);
  COV_NEST:  cover property (is_atm ##1 is_atm);

endmodule

//--- tb/lbt_dp_model.sv
// Behavioural flag register and program counter around the decoder.
`timescale 1ns/1ps
module lbt_dp_model (
  input  wire logic        core_clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        flags_we_i,
  input  wire logic [5:0]  flags_i,
  input  wire logic [5:0]  noise_i,
  input  wire logic        pc_load_i,
  input  wire logic [15:0] pc_target_i,
  output logic      [5:0]  flags_o,
  output logic      [15:0] pc_next_o
);
  // Noise stands in for the other instructions that also touch the flags.
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      flags_o   <= 6'h00;
      pc_next_o <= 16'h0100;
    end else begin
      flags_o   <= (flags_we_i ? flags_i : flags_o) ^ noise_i;
      pc_next_o <= (pc_load_i ? pc_target_i : pc_next_o) + 16'h0003;
    end
  end
endmodule

//--- tb/logic_and_bit_test_decode_tb.sv
// Random self-checking bench for the logic and bit-test decoder.
`timescale 1ns/1ps
module logic_and_bit_test_decode_tb;
  logic        clk, rst_n, valid, brk_en, irq, dma, blk, and_hit;
  logic [7:0]  op, dst, src, disp, res, e_res;
  logic [2:0]  bsel;
  logic [5:0]  noise, fl, fo, e_fl;
  logic [15:0] pcn, pt, e_pt;
  logic        rwe, fwe, pl, dbg, nop, ig, dg, ga;
  logic        e_ok, e_rwe, e_fwe, e_pl, e_dbg, e_nop, e_ig, e_dg, e_ga;
  int          bad_count, total_checks, cyc, cnt;
  integer      seed;
  logic [7:0]  ops [13] = '{8'h52, 8'h53, 8'h54, 8'h55, 8'h56, 8'h57,
                           8'h58, 8'h59, 8'h2F, 8'hF6, 8'hF7, 8'h00,
                           8'hE2};

  lbt_decode u_dut (.core_clk_i(clk), .rst_n_i(rst_n),
    .instr_valid_i(valid), .opcode_i(op), .dst_val_i(dst),
    .src_val_i(src), .bit_sel_i(bsel), .disp_i(disp), .pc_next_i(pcn),
    .flags_i(fl), .brk_enable_i(brk_en), .irq_req_i(irq),
    .dma_req_i(dma), .result_o(res), .result_we_o(rwe), .flags_o(fo),
    .flags_we_o(fwe), .pc_load_o(pl), .pc_target_o(pt),
    .dbg_break_o(dbg), .nop_o(nop), .irq_grant_o(ig), .dma_grant_o(dg),
    .guard_active_o(ga));

  lbt_dp_model u_dp (.core_clk_i(clk), .rst_n_i(rst_n), .flags_we_i(fwe),
    .flags_i(fo), .noise_i(noise), .pc_load_i(pl), .pc_target_i(pt),
    .flags_o(fl), .pc_next_o(pcn));

  task automatic check(input string nm, input logic [15:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic print_verdict();
    if (bad_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic drive();
    valid  <= ($random(seed) & 3) != 0;
    op     <= ops[$unsigned($random(seed)) % 13];
    dst    <= 8'($random(seed));
    src    <= 8'($random(seed));
    bsel   <= 3'($random(seed));
    disp   <= 8'($random(seed));
    noise  <= 6'($random(seed)) & 6'h23;
    brk_en <= 1'($random(seed));
    irq    <= 1'($random(seed));
    dma    <= 1'($random(seed));
  endtask

  // ********************************************************************
  // Reference model, evaluated on the inputs taken at each edge
  // ********************************************************************
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc > 3000) begin
      bad_count++;
      print_verdict();
    end
  end

  always @(posedge clk) begin
    e_ok    = rst_n;
    and_hit = valid && op >= 8'h52 && op <= 8'h59;
    e_res   = dst & src;
    e_rwe   = and_hit;
    e_fwe   = and_hit;
    e_fl    = {fl[5], e_res == 8'h00, e_res[7], 1'b0, fl[1:0]};
    e_pl    = valid && (op == 8'hF6 || op == 8'hF7) && !src[bsel];
    e_pt    = pcn + {{8{disp[7]}}, disp};
    e_dbg   = valid && op == 8'h00 && brk_en;
    e_nop   = valid && op == 8'h00 && !brk_en;
    blk     = (valid && op == 8'h2F) || cnt > 0;
    e_ig    = irq && !blk;
    e_dg    = dma && !blk;
    if (!rst_n) cnt = 0;
    else if (valid && op == 8'h2F) cnt = lbt_pkg::GUARD_LEN;
    else if (valid && cnt > 0) cnt--;
    e_ga    = cnt > 0;
  end

  always @(negedge clk) begin
    if (e_ok) begin
      check("result_we", rwe, e_rwe);
      if (e_rwe) check("result", res, e_res);
      check("flags_we", fwe, e_fwe);
      if (e_fwe) check("flags", fo, e_fl);
      check("pc_load", pl, e_pl);
      if (e_pl) check("pc_target", pt, e_pt);
      check("dbg_break", dbg, e_dbg);
      check("nop", nop, e_nop);
      check("irq_grant", ig, e_ig);
      check("dma_grant", dg, e_dg);
      check("guard", ga, e_ga);
    end
  end

  initial begin
    clk = 0;
    forever #12.5 clk = ~clk;
  end

  // ********************************************************************
  // Main sequence with a reset in mid-run
  // ********************************************************************
  initial begin
    seed = 20; cyc = 0; cnt = 0; bad_count = 0; total_checks = 0;
    e_ok = 0; rst_n = 0; valid = 0; op = 8'h00; dst = 8'h00;
    src = 8'h00; bsel = 3'h0; disp = 8'h00; noise = 6'h00;
    brk_en = 0; irq = 0; dma = 0;
    for (int r = 0; r < 2; r++) begin
      if (r > 0) @(posedge clk);
      rst_n <= 0;
      valid <= 0;
      irq   <= 0;
      dma   <= 0;
      repeat (2) @(posedge clk);
      rst_n <= 1;
      @(posedge clk);
      repeat (1200) begin
        @(posedge clk);
        drive();
      end
    end
    @(posedge clk);
    valid <= 0;
    repeat (2) @(posedge clk);
    print_verdict();
  end
endmodule
